/* File: hdl/fob_memory_protection_map_params.svh */
// Purpose: Constants for the fob memory and protection map.
// Assumes: Byte 0 of a block sits in bits 7:0 of the 64-bit word.
// Notes:   Block numbers double as the addresses on the access port.
//
// Overview of operation
// RULE1: Memory is eighteen blocks of eight bytes, chosen by block number.
// RULE2: Blocks 00h to 0Fh are the sixteen user EEPROM blocks.
// RULE3: User blocks form four pages of four consecutive blocks each.
// RULE4: Parameter_block holds app data in bytes 0-3, family id in byte 4.
// RULE5: Parameter block bytes 5-7 are user bytes; only byte 5 has a lock.
// RULE6: Protection_control_block holds four page bytes then four lock bytes.
// RULE7: Each page byte governs only its own page: emulation or block locks.
// RULE8: A locked field lock byte write-protects only its own field.
// RULE9: A locked self-lock byte protects only itself.
// RULE10: A control byte holding a locking code rejects all later changes.
// RULE11: Every block carries two integrity bytes outside the map.
// RULE12: Integrity bytes form a 16-bit counter bumped on every block write that is not refused.
// RULE13: Counter saturates at 65535; writes to the block still proceed.
// RULE14: The counter is returned only by the extended block read.
// RULE15: Only AAh locks a lock byte; any other value leaves it unlocked.
// RULE16: Page byte upper nibble Ah freezes it; low bits lock blocks.
// RULE17: In block-lock mode the low bits may only go from 0 to 1.
// RULE18: A refused write leaves data and counter unchanged.
`ifndef FOB_MEMORY_PROTECTION_MAP_PARAMS_SVH
`define FOB_MEMORY_PROTECTION_MAP_PARAMS_SVH

`define NUM_BLOCKS          18
`define NUM_USER_BLOCKS     16
`define BLOCK_PARAM         5'h10
`define BLOCK_CTRL          5'h11
`define LOCK_CODE           8'hAA
`define EMUL_CODE           8'h0A
`define BLOCK_MODE_NIBBLE   4'hA
`define CTR_MAX             16'hFFFF
`define BYTE_APP_DATA_LAST  3
`define BYTE_FAMILY_ID      4
`define BYTE_USER_FIRST     5
`define BYTE_APP_LOCK       4
`define BYTE_FAMILY_LOCK    5
`define BYTE_USER1_LOCK     6
`define BYTE_SELF_LOCK      7

`endif

/* File: hdl/fob_memory_protection_map_pkg.sv */
// Purpose: Types shared by the fob memory and protection map.
// Assumes: Nothing beyond the constants header.
// Notes:   Write outcome codes are reported on the access port.
package fob_memory_protection_map_pkg;
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [4:0]  block_num_t;
    typedef logic [63:0] block_data_t;
    typedef logic [15:0] cycle_count_t;
    typedef enum logic [1:0] {
        WR_DONE,
        WR_PARTIAL,
        WR_REFUSED,
        WR_BAD_ADDR
    } wr_status_e;
endpackage

/* File: hdl/fob_memory_protection_map.sv */
// Purpose: Block store with page protection, field locks and counters.
// Assumes: One access per cycle; read data registered one cycle later.
// Notes:   Emulation mode lets a user bit go only from 0 to 1 (EPROM-like).
//          Answers are registered one cycle after the request is taken.
//          clk_en low freezes the store, the counters and the answers.
`include "fob_memory_protection_map_params.svh"

module fob_memory_protection_map (
    input  wire logic                                    core_clk,
    input  wire logic                                    rst_n,
    input  wire logic                                    clk_en,
    input  wire logic                                    rd_req,
    input  wire logic                                    rd_ext,
    input  wire logic                                    wr_req,
    input  wire fob_memory_protection_map_pkg::block_num_t  blk_addr,
    input  wire fob_memory_protection_map_pkg::block_data_t wr_data,
    output logic                                         rd_valid,
    output fob_memory_protection_map_pkg::block_data_t   rd_data,
    output fob_memory_protection_map_pkg::cycle_count_t  rd_count,
    output logic                                         rd_error,
    output logic                                         wr_valid,
    output fob_memory_protection_map_pkg::wr_status_e    wr_status,
    output logic [3:0]                                   page_emul,
    output logic [15:0]                                  block_locked
);

    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================================
    // Storage
    // ========================================================================
    logic [63:0] mem      [`NUM_BLOCKS];                     // [RULE1]
    logic [15:0] wr_count [`NUM_BLOCKS];                     // [RULE11]
    logic [63:0] next_mem      [`NUM_BLOCKS];
    logic [15:0] next_wr_count [`NUM_BLOCKS];

    logic        next_rd_valid;
    logic [63:0] next_rd_data;
    logic [15:0] next_rd_count;
    logic        next_rd_error;
    logic        next_wr_valid;
    fob_memory_protection_map_pkg::wr_status_e next_wr_status;

    // ========================================================================
    // Decoding helpers
    // ========================================================================
    function automatic logic [7:0] byte_of(input logic [63:0] w,
                                           input int          i);
        byte_of = w[i*8 +: 8];
    endfunction

    // Only the exact lock code counts as locked
    function automatic logic is_locked(input logic [7:0] b);
        is_locked = (b == `LOCK_CODE);                       // [RULE15]
    endfunction

    function automatic logic is_block_mode(input logic [7:0] b);
        is_block_mode = (b[7:4] == `BLOCK_MODE_NIBBLE);      // [RULE16]
    endfunction

    // Page byte: 0Ah frozen whole; Ax keeps its nibble, low bits only set
    function automatic logic [7:0] merge_page_byte(input logic [7:0] o,
                                                   input logic [7:0] n);
        if (o == `EMUL_CODE) begin
            merge_page_byte = o;                             // [RULE10]
        end else if (is_block_mode(o)) begin
            merge_page_byte = {o[7:4], o[3:0] | n[3:0]};     // [RULE17]
        end else begin
            merge_page_byte = n;
        end
    endfunction

    // Lock byte: once it holds the lock code it never changes again
    function automatic logic [7:0] merge_lock_byte(input logic [7:0] o,
                                                   input logic [7:0] n);
        merge_lock_byte = is_locked(o) ? o : n;              // [RULE10]
    endfunction

    // Parameter bytes guarded by the three field locks right now
    function automatic logic param_byte_guarded(input logic [63:0] c,
                                                input int          i);
        logic g;
        g = 1'b0;
        if (i <= `BYTE_APP_DATA_LAST) begin
            g = is_locked(byte_of(c, `BYTE_APP_LOCK));       // [RULE8]
        end else if (i == `BYTE_FAMILY_ID) begin
            g = is_locked(byte_of(c, `BYTE_FAMILY_LOCK));    // [RULE8]
        end else if (i == `BYTE_USER_FIRST) begin
            // Bytes 6 and 7 stay free user bytes with no lock
            g = is_locked(byte_of(c, `BYTE_USER1_LOCK));     // [RULE5]
        end
        param_byte_guarded = g;
    endfunction

    // Wear count stops at its top value; the write still goes ahead
    function automatic logic [15:0] bump_count(input logic [15:0] c);
        bump_count = (c == `CTR_MAX) ? c : c + 16'h0001;     // [RULE13]
    endfunction

    // ========================================================================
    // Protection state seen from the control block
    // ========================================================================
    logic [63:0] ctrl;
    logic [63:0] prm;
    assign ctrl = mem[`BLOCK_CTRL];                          // [RULE6]
    assign prm  = mem[`BLOCK_PARAM];                         // [RULE4]

    genvar gp;
    generate
        for (gp = 0; gp < 4; gp++) begin : g_page
            logic [7:0] pb;
            assign pb = byte_of(ctrl, gp);
            // Each page byte looks after its own four blocks only
            assign page_emul[gp] = (pb == `EMUL_CODE);        // [RULE7]
            assign block_locked[gp*4 +: 4] =
                is_block_mode(pb) ? pb[3:0] : 4'h0;           // [RULE3] [RULE16]
        end
    endgenerate

    // ========================================================================
    // Write merge with protection
    // ========================================================================
    logic [63:0] merged;
    logic        any_change_refused;
    logic        blk_refused;
    logic        valid_addr;
    logic [1:0]  page_idx;

    assign valid_addr = (blk_addr < 5'(`NUM_BLOCKS));
    assign page_idx   = blk_addr[3:2];

    always_comb begin
        logic [7:0] oldb;
        logic [7:0] newb;
        oldb = 8'h00;
        newb = 8'h00;
        merged = mem[valid_addr ? blk_addr : 5'h00];
        any_change_refused = 1'b0;
        blk_refused = 1'b0;
        if (valid_addr && blk_addr < 5'(`NUM_USER_BLOCKS)) begin // [RULE2]
            if (block_locked[blk_addr[3:0]]) begin
                blk_refused = 1'b1;                          // [RULE7]
            end else if (page_emul[page_idx]) begin
                // Emulated EPROM: bits may be set, never cleared
                merged = mem[blk_addr] | wr_data;
                any_change_refused = |(mem[blk_addr] & ~wr_data);
            end else begin
                merged = wr_data;
            end
        end else if (blk_addr == `BLOCK_PARAM) begin
            for (int i = 0; i < 8; i++) begin
                oldb = byte_of(prm, i);
                newb = byte_of(wr_data, i);
                if (param_byte_guarded(ctrl, i)) begin
                    newb = oldb;                             // [RULE8]
                end
                if (newb != byte_of(wr_data, i)) begin
                    any_change_refused = 1'b1;
                end
                merged[i*8 +: 8] = newb;
            end
        end else if (blk_addr == `BLOCK_CTRL) begin
            for (int i = 0; i < 8; i++) begin
                oldb = byte_of(ctrl, i);
                newb = byte_of(wr_data, i);
                if (i < 4) begin
                    newb = merge_page_byte(oldb, newb);      // [RULE7]
                end else begin
                    // Self-lock byte guards only itself; field lock bytes also guard a parameter field
                    newb = merge_lock_byte(oldb, newb);      // [RULE9]
                end
                if (newb != byte_of(wr_data, i)) begin
                    any_change_refused = 1'b1;
                end
                merged[i*8 +: 8] = newb;
            end
        end
    end

    // ========================================================================
    // Request decode
    // ========================================================================
    // A write wins over a read offered in the same cycle
    // Requests are only taken on edges where clk_en is high
    logic take_wr;
    logic take_rd;
    logic store_en;

    assign take_wr  = wr_req;
    assign take_rd  = rd_req && !wr_req;
    // A refused block write stores nothing and counts no wear
    assign store_en = take_wr && valid_addr && !blk_refused; // [RULE18]

    // ========================================================================
    // Next state: block store and wear counters
    // ========================================================================
    always_comb begin
        for (int b = 0; b < `NUM_BLOCKS; b++) begin
            next_mem[b]      = mem[b];
            next_wr_count[b] = wr_count[b];
        end
        // Protected bytes already carry their old value inside merged
        if (store_en) begin                                  // [RULE12]
            next_mem[blk_addr]      = merged;
            next_wr_count[blk_addr] = bump_count(wr_count[blk_addr]);
        end
    end

    // ========================================================================
    // Next state: write answer
    // ========================================================================
    always_comb begin
        next_wr_valid  = take_wr;
        next_wr_status = wr_status;
        if (take_wr) begin
            if (!valid_addr) begin
                next_wr_status =
                    fob_memory_protection_map_pkg::WR_BAD_ADDR;
            end else if (blk_refused) begin
                next_wr_status =
                    fob_memory_protection_map_pkg::WR_REFUSED;  // [RULE18]
            end else if (any_change_refused) begin
                // Protected bytes or emulated bits kept their value, the rest was stored
                next_wr_status =
                    fob_memory_protection_map_pkg::WR_PARTIAL;
            end else begin
                next_wr_status =
                    fob_memory_protection_map_pkg::WR_DONE;
            end
        end
    end

    // ========================================================================
    // Next state: read answer
    // ========================================================================
    always_comb begin
        next_rd_valid = take_rd;
        next_rd_error = 1'b0;
        next_rd_data  = rd_data;
        next_rd_count = rd_count;
        if (take_rd) begin
            if (!valid_addr) begin
                // Out of the map: flag it and show nothing stale
                next_rd_error = 1'b1;
                next_rd_data  = 64'h0;
                next_rd_count = 16'h0000;
            end else begin
                next_rd_data  = mem[blk_addr];
                // Counter leaves the block only on an extended read
                next_rd_count = rd_ext ? wr_count[blk_addr]
                                       : 16'h0000;           // [RULE14]
            end
        end
    end

    // ========================================================================
    // Registers: block store
    // ========================================================================
    // Factory state is all zero: every page unlocked, no field locked
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int b = 0; b < `NUM_BLOCKS; b++) begin
                mem[b]      <= 64'h0;
                wr_count[b] <= 16'h0000;
            end
        end else if (clk_en) begin
            for (int b = 0; b < `NUM_BLOCKS; b++) begin
                mem[b]      <= next_mem[b];
                wr_count[b] <= next_wr_count[b];
            end
        end
    end

    // ========================================================================
    // Registers: write answer
    // ========================================================================
    // Status holds until the next write answer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_valid  <= 1'b0;
            wr_status <= fob_memory_protection_map_pkg::WR_DONE;
        end else if (clk_en) begin
            wr_valid  <= next_wr_valid;
            wr_status <= next_wr_status;
        end
    end

    // ========================================================================
    // Registers: read answer
    // ========================================================================
    // Data and count hold until the next read answer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_data  <= 64'h0;
            rd_count <= 16'h0000;
            rd_error <= 1'b0;
        end else if (clk_en) begin
            rd_valid <= next_rd_valid;
            rd_data  <= next_rd_data;
            rd_count <= next_rd_count;
            rd_error <= next_rd_error;
        end
    end

endmodule

/* File: test/fob_map_checker.sv */
// Purpose: Port checks for the fob memory and protection map.
// Assumes: One clock; clk_en qualifies every request.
// Notes:   Bound to the design from the testbench top file.
module fob_map_checker (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        clk_en,
    input wire logic        rd_req,
    input wire logic        rd_ext,
    input wire logic        wr_req,
    input wire logic [4:0]  blk_addr,
    input wire logic        rd_valid,
    input wire logic [15:0] rd_count,
    input wire logic        rd_error,
    input wire logic        wr_valid,
    input wire logic [1:0]  wr_status,
    input wire logic [3:0]  page_emul,
    input wire logic [15:0] block_locked
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic tk_wr;
    logic tk_rd;
    assign tk_wr = clk_en && wr_req;
    assign tk_rd = clk_en && rd_req && !wr_req;
    // ==========================================================
    // Answers
    AST_WR_ANSWER: assert property (tk_wr |=> wr_valid)
        else $error("write answer missing");
    AST_RD_ANSWER: assert property (tk_rd |=> rd_valid)
        else $error("read answer missing");
    AST_BAD_ADDR: assert property (tk_rd && blk_addr > 5'h11
        |=> rd_valid && rd_error) else $error("bad address not flagged");
    AST_PLAIN_NO_COUNT: assert property (tk_rd && !rd_ext
        |=> rd_count == 16'h0) else $error("plain read gave count");
    // ==========================================================
    // Protection
    AST_LOCKED_REFUSED: assert property (tk_wr && blk_addr < 5'h10
        && block_locked[blk_addr[3:0]] |=> wr_status == 2'h2)
        else $error("locked block write not refused");
    AST_FREE_DONE: assert property (tk_wr && blk_addr < 5'h10
        && !block_locked[blk_addr[3:0]] && !page_emul[blk_addr[3:2]]
        |=> wr_status == 2'h0) else $error("free block write not done");
    AST_LOCK_STICKY: assert property ((block_locked
        & $past(block_locked)) == $past(block_locked))
        else $error("block lock bit cleared");
    AST_EMUL_STICKY: assert property ($fell(page_emul[0]) == 1'b0
        && (page_emul & $past(page_emul)) == $past(page_emul))
        else $error("emulation mode left");
    for (genvar p = 0; p < 4; p++) begin : g_pg
        AST_MODE_SPLIT: assert property (page_emul[p]
            |-> block_locked[4*p +: 4] == 4'h0)
            else $error("emulation page shows block locks");
    end
endmodule

/* File: test/fob_reader_model.sv */
// Purpose: Reader side issuing block reads and writes.
// Assumes: Answer arrives one edge after the request is taken.
// Notes:   Idle address and data are inverted so stale values fail.
module fob_reader_model (
    input  wire logic   core_clk,
    output logic        clk_en,
    output logic        rd_req,
    output logic        rd_ext,
    output logic        wr_req,
    output logic [4:0]  blk_addr,
    output logic [63:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        clk_en = 1'b1;
        rd_req = 1'b0;
        rd_ext = 1'b0;
        wr_req = 1'b0;
        blk_addr = 5'h1F;
        wr_data = 64'h0;
    end
    task automatic wr(input logic [4:0] a, input logic [63:0] d);
        @(posedge core_clk);
        #1;
        wr_req = 1'b1;
        blk_addr = a;
        wr_data = d;
        @(posedge core_clk);
        #1;
        wr_req = 1'b0;
        blk_addr = ~a;
        wr_data = ~d;
    endtask
    // Counter only comes back on the extended read
    task automatic rd(input logic [4:0] a, input logic x);
        @(posedge core_clk);
        #1;
        rd_req = 1'b1;
        rd_ext = x;
        blk_addr = a;
        @(posedge core_clk);
        #1;
        rd_req = 1'b0;
        rd_ext = ~x;
        blk_addr = ~a;
    endtask
    // Back-to-back writes: the request stands for n taking edges
    task automatic wr_burst(input logic [4:0] a, input logic [63:0] d,
                            input int n);
        @(posedge core_clk);
        #1;
        wr_req = 1'b1;
        blk_addr = a;
        wr_data = d;
        repeat (n) @(posedge core_clk);
        #1;
        wr_req = 1'b0;
        blk_addr = ~a;
        wr_data = ~d;
    endtask
    task automatic set_en(input logic e);
        @(posedge core_clk);
        #1;
        clk_en = e;
    endtask
endmodule

/* File: test/tb_fob_memory_protection_map.sv */
// Purpose: Scenario bench for the fob memory and protection map.
// Assumes: Reader model drives all requests.
// Notes:   The wear scenario runs 65535 back-to-back writes to one block.
module tb_fob_memory_protection_map;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        clk_en, rd_req, rd_ext, wr_req, rd_valid, rd_error, wr_valid;
    logic [4:0]  blk_addr;
    logic [63:0] wr_data, rd_data;
    logic [15:0] rd_count, block_locked;
    logic [3:0]  page_emul;
    int          err_count = 0;
    int          checked = 0;
    fob_memory_protection_map_pkg::wr_status_e wr_status;
    localparam logic [1:0] DONE = fob_memory_protection_map_pkg::WR_DONE;
    localparam logic [1:0] PART = fob_memory_protection_map_pkg::WR_PARTIAL;
    localparam logic [1:0] REFU = fob_memory_protection_map_pkg::WR_REFUSED;
    localparam logic [1:0] BADA = fob_memory_protection_map_pkg::WR_BAD_ADDR;
    localparam logic [63:0] D = 64'h0123_4567_89AB_CDEF;
    fob_memory_protection_map fob_memory_protection_map_inst (.*);
    fob_reader_model fob_reader_model_inst (.*);
    always #20 core_clk = ~core_clk;
    task automatic chk(input string n, input logic [63:0] s, e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic w(input logic [4:0] a, input logic [63:0] d);
        fob_reader_model_inst.wr(a, d);
    endtask
    task automatic r(input logic [4:0] a, input logic x);
        fob_reader_model_inst.rd(a, x);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_user();
        w(5'h05, D);
        chk("status", wr_status, DONE);
        chk("wr_valid", wr_valid, 1);
        r(5'h05, 1'b1);
        chk("rd_valid", rd_valid, 1);
        chk("data", rd_data, D);
        chk("count", rd_count, 1);
        r(5'h05, 1'b0);
        chk("plain count", rd_count, 0);
    endtask
    task automatic t_param_bad();
        w(5'h10, 64'hC3C3_C3C3_1234_5678);
        r(5'h10, 1'b0);
        chk("param", rd_data, 64'hC3C3_C3C3_1234_5678);
        r(5'h12, 1'b0);
        chk("rd_error", rd_error, 1);
        w(5'h1F, D);
        chk("bad status", wr_status, BADA);
    endtask
    task automatic t_blocks();
        w(5'h11, 64'hA200);
        chk("locked", block_locked, 16'h0020);
        w(5'h05, ~D);
        chk("status", wr_status, REFU);
        r(5'h05, 1'b1);
        chk("kept", rd_data, D);
        chk("kept count", rd_count, 1);
        w(5'h11, 64'h0);
        chk("no unlock", block_locked, 16'h0020);
        w(5'h11, 64'hA900);
        chk("or bits", block_locked, 16'h00B0);
    endtask
    task automatic t_emul();
        w(5'h11, 64'h0A_0000);
        chk("emul", page_emul, 4'h4);
        w(5'h08, 64'hF0);
        w(5'h08, 64'h0F);
        chk("status", wr_status, PART);
        r(5'h08, 1'b1);
        chk("or data", rd_data, 64'hFF);
        chk("count", rd_count, 2);
        w(5'h11, 64'h0);
        chk("frozen", page_emul, 4'h4);
    endtask
    task automatic t_locks();
        w(5'h11, 64'hAA00_55AA_0000_0000);
        w(5'h10, '1);
        chk("status", wr_status, PART);
        r(5'h10, 1'b0);
        chk("fields", rd_data, 64'hFFFF_FFFF_1234_5678);
        w(5'h11, 64'h0);
        r(5'h11, 1'b1);
        chk("ctrl", rd_data, 64'hAA00_00AA_000A_AB00);
        chk("ctrl count", rd_count, 7);
    endtask
    task automatic t_freeze();
        fob_reader_model_inst.set_en(1'b0);
        w(5'h06, D);
        chk("frozen answer", wr_valid, 0);
        fob_reader_model_inst.set_en(1'b1);
        r(5'h06, 1'b1);
        chk("frozen data", rd_data, 0);
        chk("frozen count", rd_count, 0);
    endtask
    task automatic t_wear();
        fob_reader_model_inst.wr_burst(5'h0C, ~D, 65535);
        r(5'h0C, 1'b1);
        chk("sat count", rd_count, 16'hFFFF);
        w(5'h0C, D);
        chk("sat status", wr_status, DONE);
        r(5'h0C, 1'b1);
        chk("sat data", rd_data, D);
        chk("sat hold", rd_count, 16'hFFFF);
    endtask
    initial begin
        #3000000;
        err_count++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        chk("reset locks", block_locked, 16'h0);
        chk("reset emul", page_emul, 4'h0);
        t_user();
        t_param_bad();
        t_blocks();
        t_emul();
        t_locks();
        t_freeze();
        t_wear();
        print_verdict();
    end
endmodule
bind fob_memory_protection_map fob_map_checker fob_map_checker_inst (.*);
